// ==== rtl/word_loader_defines.svh ====
// offsets, field codes and timing counts of the reconfiguration word loader
// assumes inclusion by bare name from the loader module and the bench
`ifndef WORD_LOADER_DEFINES_SVH
`define WORD_LOADER_DEFINES_SVH

// apb register byte offsets
`define REG_CTRL        12'h000
`define REG_SEL         12'h004
`define REG_STATUS      12'h008
`define REG_IRQ_STAT    12'h00C
`define REG_IRQ_MASK    12'h010
`define REG_WORD        12'h014

// control register fields
`define CTRL_CONT_BIT   0
`define CTRL_ILLEGAL_BIT 1
`define CTRL_RECOV_BIT  2
`define CTRL_QUAL_BIT   3
`define CTRL_DUPLEX_BIT 4
`define CTRL_RESET      8'h1F

// interrupt status bits
`define IRQ_DONE_BIT    0
`define IRQ_ERR_BIT     1
`define IRQ_RECOV_BIT   2

// mode codes on the mode input
`define MODE_PLL_ONLY   2'h0
`define MODE_CHAN_PLL   2'h1
`define MODE_CHAN_TXSEL 2'h2
`define MODE_RATE_DIV   2'h3

// direction select codes
`define DIR_DUPLEX      2'h0
`define DIR_RX_ONLY     2'h1
`define DIR_TX_ONLY     2'h2
`define DIR_BAD         2'h3

// local divider codes
`define DIV_BY_1        2'h0
`define DIV_BY_2        2'h1
`define DIV_BY_4        2'h2

// timing
`define ERR_HOLD_CYCLES 2
`define READ_LAT_DEF    2
`define WORDS_DEF       6'h3F
`define TIMEOUT_NS      50000
`define CLK_PERIOD_NS   10
`define TIMEOUT_CYCLES  (`TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// ==== rtl/word_loader_pkg.sv ====
// types of the reconfiguration word loader
// assumes the defines header sits beside it
package word_loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WAIT,
        ST_TAKE,
        ST_ERR
    } loader_state_t;
endpackage

// ==== rtl/sync_bit.sv ====
// two flip-flop synchroniser for one level input
// assumes the input is asynchronous to pclk
`timescale 1ns/1ps
module sync_bit
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // level
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule

// ==== rtl/word_counter.sv ====
// down counter that reports expiry, reused for read latency and timeout
// assumes load and run are from pclk logic
`timescale 1ns/1ps
module word_counter
#(
    parameter int W = 16
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clk_en,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         run,
    output logic              expired
);
    logic [W-1:0] cnt_ff;

    // load wins over counting, stops at zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= '0;
        else if (clk_en)
        begin
            if (load)
                cnt_ff <= load_val;
            else if (run && cnt_ff != '0)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign expired = run && !load && (cnt_ff == '0);
endmodule

// ==== rtl/word_loader.sv ====
// reconfiguration word loader: steps word addresses, samples words, apb control
// assumes word memory on pclk answers read_lat cycles after the address
`timescale 1ns/1ps
`include "word_loader_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - with continuous write on, one write-all pulse loads words up to the last-word register.
// - with continuous write on, each word is sampled read-latency cycles after its address appears.
// - read latency applies only in continuous write; else one word per request.
// - six-bit word address output increments at end of each word write.
// - address-changed output pulses when the last word write of a request completes, with busy falling.
// - address-clear input sets the word address to zero.
// - pll-only mode reconfigures the pll chosen by the select input.
// - combined mode reconfigures selected pll and clocks channel from it.
// - tx-pll-select mode switches channel to the selected transmit pll.
// - with qualifier enabled, pll select counts only while qualifier is one.
// - illegal mode found within two cycles; busy stays low, error high two cycles.
// - self recovery on timeout during the read-latency wait state, driving the error output high.
// - divider output: 00 divide 1, 01 divide 2, 10 divide 4.
// - direction select: 00 both, 01 receiver only, 10 transmitter only.
// - without direction select, both sides are always accessed.
module word_loader
    import word_loader_pkg::*;
#(
    parameter int         LAT_W          = 4,
    parameter int         TO_W           = 16,
    parameter int         TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
    parameter logic [3:0] READ_LAT       = `READ_LAT_DEF
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // user requests, asynchronous pins
    input  wire logic        write_all,
    input  wire logic        write_one,
    input  wire logic        addr_clear,
    input  wire logic        pll_sel_qual,
    input  wire logic [1:0]  pll_sel,
    input  wire logic [1:0]  dir_sel,
    input  wire logic [1:0]  mode_sel,
    // word memory, on pclk
    input  wire logic [15:0] word_data,
    output logic      [5:0]  word_addr,
    output logic             addr_changed,
    output logic             busy,
    output logic             error,
    // transceiver side
    output logic      [15:0] xcvr_word,
    output logic             xcvr_word_vld,
    output logic      [1:0]  clock_multiplier_pll_sel,
    output logic      [1:0]  chan_clk_src,
    output logic             chan_clk_src_vld,
    output logic             rx_access,
    output logic             tx_access,
    output logic      [1:0]  tx_div
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [9:0] raw_in;
    logic [9:0] sync_in;
    assign raw_in = {mode_sel, dir_sel, pll_sel, pll_sel_qual, addr_clear, write_one, write_all};

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_sync
            sync_bit u_sync
            (
                .pclk    (pclk),
                .presetn (presetn),
                .clk_en  (clk_en),
                .din     (raw_in[gi]),
                .dout    (sync_in[gi])
            );
        end
    endgenerate

    logic       wr_all_s, wr_one_s, clr_s, qual_s;
    logic [1:0] psel_s, dir_s, mode_s;
    assign wr_all_s = sync_in[0];
    assign wr_one_s = sync_in[1];
    assign clr_s    = sync_in[2];
    assign qual_s   = sync_in[3];
    assign psel_s   = sync_in[5:4];
    assign dir_s    = sync_in[7:6];
    assign mode_s   = sync_in[9:8];

    // edge detect on the synchronised requests
    logic wr_all_d_ff, wr_one_d_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_all_d_ff <= 1'b0;
            wr_one_d_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_all_d_ff <= wr_all_s;
            wr_one_d_ff <= wr_one_s;
        end
    end
    logic all_req, one_req;
    assign all_req = wr_all_s & ~wr_all_d_ff;
    assign one_req = wr_one_s & ~wr_one_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    logic [7:0]  ctrl_ff;
    logic [5:0]  last_word_ff;
    logic [2:0]  irq_stat_ff, irq_mask_ff;
    logic        cont_en, illegal_en, recov_en, qual_en, duplex_pin_en;
    assign cont_en       = ctrl_ff[`CTRL_CONT_BIT];
    assign illegal_en    = ctrl_ff[`CTRL_ILLEGAL_BIT];
    assign recov_en      = ctrl_ff[`CTRL_RECOV_BIT];
    assign qual_en       = ctrl_ff[`CTRL_QUAL_BIT];
    assign duplex_pin_en = ctrl_ff[`CTRL_DUPLEX_BIT];

    logic apb_wr, apb_rd;
    assign pready  = 1'b1;
    assign apb_wr  = psel & penable & pwrite;
    assign apb_rd  = psel & penable & ~pwrite;
    logic mapped;
    assign mapped  = (paddr == `REG_CTRL) || (paddr == `REG_SEL) || (paddr == `REG_STATUS)
                  || (paddr == `REG_IRQ_STAT) || (paddr == `REG_IRQ_MASK) || (paddr == `REG_WORD);
    assign pslverr = psel & penable & ~mapped;

    // control, last word and mask writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff      <= `CTRL_RESET;
            last_word_ff <= `WORDS_DEF;
            irq_mask_ff  <= 3'h0;
        end
        else if (clk_en && apb_wr)
        begin
            if (paddr == `REG_CTRL)
                ctrl_ff <= pwdata[7:0];
            if (paddr == `REG_SEL)
                last_word_ff <= pwdata[5:0];
            if (paddr == `REG_IRQ_MASK)
                irq_mask_ff <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode and select decode
    logic sel_valid, dir_bad, mode_bad;
    assign sel_valid = !qual_en || qual_s;
    assign dir_bad   = duplex_pin_en && (dir_s == `DIR_BAD);
    assign mode_bad  = (mode_s != `MODE_RATE_DIV) && !sel_valid;

    // access direction; without the pin both sides are touched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_access <= 1'b0;
            tx_access <= 1'b0;
        end
        else if (clk_en && busy)
        begin
            if (!duplex_pin_en)
            begin
                rx_access <= 1'b1;
                tx_access <= 1'b1;
            end
            else
            begin
                rx_access <= (dir_s == `DIR_DUPLEX) || (dir_s == `DIR_RX_ONLY);
                tx_access <= (dir_s == `DIR_DUPLEX) || (dir_s == `DIR_TX_ONLY);
            end
        end
        else if (clk_en)
        begin
            rx_access <= 1'b0;
            tx_access <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    loader_state_t state_ff, nxt_state;
    logic [1:0]    err_cnt_ff;
    logic          cont_run_ff;
    logic          lat_exp, to_exp, lat_load, word_done;

    word_counter #(.W(LAT_W)) u_lat
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .load     (lat_load),
        .load_val (LAT_W'(READ_LAT - 4'h2)),                               // address cycle counts toward latency
        .run      (state_ff == ST_WAIT),
        .expired  (lat_exp)
    );

    word_counter #(.W(TO_W)) u_to
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .load     (state_ff == ST_IDLE),
        .load_val (TO_W'(TIMEOUT_CYCLES)),
        .run      (busy && recov_en),
        .expired  (to_exp)
    );

    assign lat_load  = (state_ff == ST_ADDR);
    assign word_done = (state_ff == ST_TAKE);
    logic accept;
    assign accept = (state_ff == ST_IDLE) && (all_req && cont_en || one_req);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (accept)
                    nxt_state = (illegal_en && (dir_bad || mode_bad)) ? ST_ERR : ST_ADDR;
            ST_ADDR:
                nxt_state = (cont_en && READ_LAT > 4'h1) ? ST_WAIT : ST_TAKE;
            ST_WAIT:
                if (to_exp)
                    nxt_state = ST_ERR;
                else if (lat_exp)
                    nxt_state = ST_TAKE;
            ST_TAKE:
                nxt_state = (cont_run_ff && word_addr != last_word_ff) ? ST_ADDR : ST_IDLE;
            ST_ERR:
                if (err_cnt_ff == 2'(`ERR_HOLD_CYCLES - 1))
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= ST_IDLE;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // continuous run flag, taken at acceptance
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cont_run_ff <= 1'b0;
        else if (clk_en && accept)
            cont_run_ff <= all_req && cont_en;
    end

    // error hold counter and output, two cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_cnt_ff <= 2'h0;
        else if (clk_en)
            err_cnt_ff <= (state_ff == ST_ERR) ? err_cnt_ff + 2'h1 : 2'h0;
    end
    assign error = (state_ff == ST_ERR);
    // busy drops as soon as the error is raised
    assign busy  = (state_ff == ST_ADDR) || (state_ff == ST_WAIT) || (state_ff == ST_TAKE);

    ////////////////////////////////////////////////////////////////////////////
    // word address and word capture
    logic [5:0] addr_ff;
    assign word_addr = addr_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            addr_ff <= 6'h00;
        else if (clk_en)
        begin
            if (clr_s)
                addr_ff <= 6'h00;
            else if (word_done)
                addr_ff <= addr_ff + 6'h01;
        end
    end

    // word forwarded to the transceiver when sampled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xcvr_word     <= 16'h0000;
            xcvr_word_vld <= 1'b0;
            addr_changed  <= 1'b0;
        end
        else if (clk_en)
        begin
            xcvr_word_vld <= word_done;
            addr_changed  <= word_done && (nxt_state == ST_IDLE);
            if (word_done)
                xcvr_word <= word_data;
        end
    end

    // pll and clock source selection per mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_multiplier_pll_sel <= 2'h0;
            chan_clk_src             <= 2'h0;
            chan_clk_src_vld         <= 1'b0;
            tx_div                   <= `DIV_BY_1;
        end
        else if (clk_en && accept && sel_valid)
        begin
            chan_clk_src_vld <= 1'b0;
            case (mode_s)
                `MODE_PLL_ONLY:
                    clock_multiplier_pll_sel <= psel_s;
                `MODE_CHAN_PLL:
                begin
                    clock_multiplier_pll_sel <= psel_s;
                    chan_clk_src             <= psel_s;
                    chan_clk_src_vld         <= 1'b1;
                end
                `MODE_CHAN_TXSEL:
                begin
                    chan_clk_src     <= psel_s;
                    chan_clk_src_vld <= 1'b1;
                end
                default:
                    if (psel_s != 2'h3)
                        tx_div <= psel_s;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, set wins
    logic [2:0] irq_set;
    assign irq_set = {to_exp && recov_en, nxt_state == ST_ERR && state_ff != ST_ERR, addr_changed};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_ff <= 3'h0;
        else if (clk_en)
            irq_stat_ff <= (irq_stat_ff & ~((apb_wr && paddr == `REG_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | irq_set;
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // read mux
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (apb_rd)
        begin
            case (paddr)
                `REG_CTRL:     prdata = {24'h00_0000, ctrl_ff};
                `REG_SEL:      prdata = {26'h000_0000, last_word_ff};
                `REG_STATUS:   prdata = {22'h00_0000, tx_div, addr_ff, error, busy};
                `REG_IRQ_STAT: prdata = {29'h0000_0000, irq_stat_ff};
                `REG_IRQ_MASK: prdata = {29'h0000_0000, irq_mask_ff};
                `REG_WORD:     prdata = {16'h0000, xcvr_word};
                default:       prdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    addr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && word_done && !clr_s |=> addr_ff == $past(addr_ff) + 6'h01)
        else $error("word address did not step");
    addr_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && clr_s |=> addr_ff == 6'h00)
        else $error("word address not cleared");
    err_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && $rose(error) |-> !busy ##1 (clk_en -> error))
        else $error("error not held with busy low");
    done_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        addr_changed |-> !busy)
        else $error("address change while busy");
    dir_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && busy && $past(busy) && duplex_pin_en && dir_s == `DIR_RX_ONLY && $stable(dir_s) |=> !tx_access || !busy)
        else $error("transmit touched in receive only");
    both_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && busy && !duplex_pin_en |=> rx_access && tx_access)
        else $error("both sides not accessed");
    div_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_div != 2'h3)
        else $error("unsupported divider code");
    qual_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && accept && qual_en && !qual_s |=> $stable(chan_clk_src))
        else $error("select taken without qualifier");
    lat_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_ff == ST_ADDR && cont_en && !recov_en |-> ##[1:16] state_ff == ST_TAKE)
        else $error("word not sampled after latency");
endmodule

// ==== verif/word_mem_model.sv ====
// word memory model: answers each word address with a fixed pattern
// assumes a registered pclk address and LAT of 1 or more
`timescale 1ns/1ps
module word_mem_model
#(
    parameter int LAT = 2
)
(
    // clock
    input  wire logic        pclk,
    // word port
    input  wire logic [5:0]  word_addr,
    output logic      [15:0] word_data
);
    logic [5:0] addr_pipe [LAT];

    ////////////////////////////////////////////////////////////
    // address delay line; stale data shows the previous word, so an early sample is caught
    always_ff @(posedge pclk)
    begin
        addr_pipe[0] <= word_addr;
        for (int i = 1; i < LAT; i++)
            addr_pipe[i] <= addr_pipe[i - 1];
    end

    // word content: fixed upper byte over the address
    assign word_data = {8'hA5, 2'h0, addr_pipe[LAT - 1]};
endmodule

// ==== verif/transceiver_reconfig_word_loader_tb.sv ====
// bench of the word loader: apb tasks, request pins, word memory model
// assumes the rtl folder is on the include path
`timescale 1ns/1ps
`include "word_loader_defines.svh"
module transceiver_reconfig_word_loader_tb
    import word_loader_pkg::*;
;
    // design ports and bench state
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, write_all, write_one, addr_clear, pll_sel_qual;
    logic        pready, pslverr, irq, addr_changed, busy, error, xcvr_word_vld, rx_access, tx_access, se, chk_data;
    logic        src_vld, rx_seen, tx_seen;
    logic [1:0]  pll_sel, dir_sel, mode_sel, clock_multiplier_pll_sel, chan_clk_src, tx_div;
    logic [5:0]  word_addr;
    logic [11:0] paddr;
    logic [15:0] word_data, xcvr_word;
    logic [31:0] pwdata, prdata, rd;
    int          err_total, n_checks, n_vld, n_chg, n_err, n_busy;

    word_loader #(.TIMEOUT_CYCLES(20), .READ_LAT(4'h2)) DUT
    (
        .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .write_all, .write_one, .addr_clear, .pll_sel_qual, .pll_sel, .dir_sel, .mode_sel,
        .word_data, .word_addr, .addr_changed, .busy, .error, .xcvr_word, .xcvr_word_vld,
        .clock_multiplier_pll_sel, .chan_clk_src, .chan_clk_src_vld(src_vld), .rx_access, .tx_access, .tx_div
    );
    word_mem_model #(.LAT(2)) mem (.pclk, .word_addr, .word_data);

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // per-cycle counts, taken at the falling edge where outputs have settled
    always @(negedge pclk)
    begin
        if (xcvr_word_vld === 1'b1) n_vld++;
        if (addr_changed === 1'b1) n_chg++;
        if (error === 1'b1) n_err++;
        if (busy === 1'b1) n_busy++;
        // access lines only stand while busy, so keep the last busy value
        if (busy === 1'b1)
        begin
            rx_seen = rx_access;
            tx_seen = tx_access;
        end
        if (xcvr_word_vld === 1'b1 && chk_data === 1'b1)
            chk("word", {16'h0, 8'hA5, 2'h0, word_addr - 6'h1}, 32'(xcvr_word));
    end

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // pulse a request pin, then wait, bounded, for busy to rise and fall
    task automatic run(input logic all);
        n_vld = 0;
        n_chg = 0;
        n_err = 0;
        n_busy = 0;
        rx_seen = 1'b0;
        tx_seen = 1'b0;
        @(posedge pclk);
        write_all <= all;
        write_one <= ~all;
        repeat (2) @(posedge pclk);
        write_all <= 1'b0;
        write_one <= 1'b0;
        @(negedge pclk);
        for (int k = 0; k < 50 && busy !== 1'b1; k++) @(negedge pclk);
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge pclk);
        repeat (4) @(negedge pclk);
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // main sequence; each step drives just after a rising edge
    initial
    begin
        {psel, penable, pwrite, write_all, write_one, addr_clear, pll_sel_qual, chk_data} = '0;
        {pll_sel, dir_sel, mode_sel, paddr, pwdata} = '0;
        err_total = 0;
        n_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", `REG_CTRL, 32'h1F);
        rdchk("last", `REG_SEL, 32'h3F);
        rdchk("mask", `REG_IRQ_MASK, 32'h0);
        rdchk("bad", 12'h018, 32'h0);
        chk("slverr", 32'h1, 32'(se));
        // four-word continuous load with interrupts masked
        apb(1'b1, `REG_SEL, 32'h3);
        apb(1'b1, `REG_CTRL, 32'h13);
        apb(1'b1, `REG_IRQ_MASK, 32'h0);
        chk_data = 1'b1;
        pll_sel <= 2'h2;
        run(1'b1);
        chk_data = 1'b0;
        chk("words", 32'h4, 32'(n_vld));
        chk("chg", 32'h1, 32'(n_chg));
        chk("irq", 32'h0, 32'(irq));
        rdchk("wreg", `REG_WORD, 32'hA503);
        // address clear held past the synchroniser
        @(posedge pclk);
        addr_clear <= 1'b1;
        repeat (3) @(posedge pclk);
        addr_clear <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("clear", 32'h0, 32'(word_addr));
        // single word without continuous mode
        apb(1'b1, `REG_CTRL, 32'h12);
        run(1'b0);
        chk("one", 32'h1, 32'(n_vld));
        chk("addr", 32'h1, 32'(word_addr));
        chk("chg1", 32'h1, 32'(n_chg));
        // every mode against select and direction codes 0 to 2
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 3; s++)
            begin
                @(posedge pclk);
                mode_sel <= 2'(m);
                pll_sel <= 2'(s);
                dir_sel <= 2'(s);
                run(1'b0);
                if (m < 2) chk("pll", 32'(s), 32'(clock_multiplier_pll_sel));
                if (m == 1 || m == 2) chk("src", 32'(s), 32'(chan_clk_src));
                chk("srcv", 32'(m == 1 || m == 2), 32'(src_vld));
                if (m == 3) chk("div", 32'(s), 32'(tx_div));
                chk("rx", 32'(s != 2), 32'(rx_seen));
                chk("tx", 32'(s != 1), 32'(tx_seen));
            end
        // unsupported direction code is refused; its interrupt is unmasked then cleared
        @(posedge pclk);
        dir_sel <= 2'h3;
        run(1'b0);
        chk("err", 32'h2, 32'(n_err));
        chk("busy", 32'h0, 32'(n_busy));
        apb(1'b1, `REG_IRQ_MASK, 32'h2);
        @(negedge pclk);
        chk("irq on", 32'h1, 32'(irq));
        apb(1'b1, `REG_IRQ_STAT, 32'h7);
        @(negedge pclk);
        chk("irq off", 32'h0, 32'(irq));
        // direction pin disabled: both sides accessed
        apb(1'b1, `REG_CTRL, 32'h02);
        dir_sel <= 2'h1;
        run(1'b0);
        chk("rx2", 32'h1, 32'(rx_seen));
        chk("tx2", 32'h1, 32'(tx_seen));
        // qualifier low refuses, high accepts
        apb(1'b1, `REG_CTRL, 32'h0A);
        mode_sel <= 2'h1;
        pll_sel <= 2'h1;
        run(1'b0);
        chk("unq", 32'h2, 32'(n_err));
        chk("unqsrc", 32'h2, 32'(chan_clk_src));
        @(posedge pclk);
        pll_sel_qual <= 1'b1;
        run(1'b0);
        chk("qual", 32'h1, 32'(n_vld));
        chk("qsrc", 32'h1, 32'(chan_clk_src));
        // a long load outlasts the shortened timeout and recovers
        apb(1'b1, `REG_IRQ_STAT, 32'h7);
        apb(1'b1, `REG_SEL, 32'h3F);
        apb(1'b1, `REG_CTRL, 32'h05);
        run(1'b1);
        chk("recov", 32'h2, 32'(n_err));
        apb(1'b0, `REG_IRQ_STAT, 32'h0);
        chk("recirq", 32'h1, 32'(rd[2]));
        print_verdict;
    end

    // watchdog, about fifty times the expected run
    initial
    begin
        #200000;
        err_total++;
        print_verdict;
    end
endmodule
